// ===== verilog/flash_seq_defines.svh
// Constants for the flash sequencer status and query path
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH
`define ADDR_UNLOCK1   12'h555
`define ADDR_UNLOCK2   12'hAAA
`define CODE_UNLOCK1   8'hAA
`define CODE_UNLOCK2   8'h55
`define CODE_QUERY     8'h90
`define CODE_PROGRAM   8'hA0
`define CODE_ERASE     8'h80
`define CODE_BULK      8'h10
`define CODE_SECTOR    8'h30
`define CODE_RESET     8'hF0
`define QSEL_ID        3'h1
`define QSEL_PROT      3'h2
`define STEP_PGM_DATA  3'h6
`define BANK0_SECTORS  12'h0FF
`define BANK1_SECTORS  12'hF00
`define POLL_BIT       7
`define TOGGLE_BIT     6
`define ERROR_BIT      5
`define WINDOW_BIT     3
`define TMR_W          16
`define CLK_MHZ        25
`define WINDOW_US      100
`define WINDOW_CYC     (`WINDOW_US * `CLK_MHZ)
`endif

// ===== verilog/flash_seq_pkg.sv
// Types shared by the flash sequencer status and query path
package flash_seq_pkg;
	typedef enum logic [2:0] {
		S_READ, S_QRY, S_PROG, S_WIN, S_ERASE, S_NOERASE, S_ERR
	} seq_state_t;
endpackage

// ===== verilog/flash_status_seq.sv
// Command decode and status reads for the primary and secondary flash arrays
`timescale 1ns/100ps
`include "flash_seq_defines.svh"

// Contract
// R1 - Three writes then read 001 gives identifier (code: primary array only; secondary returns array data)
// R2 - Three writes then read 010 queries protection
// R3 - Protection read gives 01h or 00h
// R4 - Status reads repeat freely while algorithm runs
// R5 - Program polling bit is inverted data bit
// R6 - Flags valid after fourth or sixth write
// R7 - Erase polling bit zero until done
// R8 - Program into protected sector is ignored
// R9 - All protected erase: polling zero, no erase
// R10 - Toggle bit flips on every busy read (code: held zero in S_NOERASE, which still drives busy)
// R11 - Toggling stops, array data returns when done
// R12 - Host ends on two equal reads
// R13 - All protected erase: toggle held zero
// R14 - Error flag zero unless operation fails
// R15 - Error on zero to one program
// R16 - Host abandons a failed sector
// R17 - Reset command clears error flag
// R18 - Erase window flag low during window
// R19 - Commands open with two unlock writes
// R20 - F0h write returns to array reads
// R21 - Sector selects pick primary or secondary
// R22 - Other status bits read as zero
// R23 - Idle array reads normally during busy
module flash_status_seq
	import flash_seq_pkg::*;
#(
	parameter int         PROG_CYC  = 16,
	parameter int         ERASE_CYC = 64,
	parameter logic [7:0] ID_CODE   = 8'h5A // Arbitrary identifier value
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [7:0]  primary_sector_selects,
	input  wire logic [3:0]  secondary_sector_selects,
	input  wire logic [7:0]  array_rdata,
	input  wire logic [11:0] sector_protect,
	input  wire logic        op_fail,
	output logic      [7:0]  rdata,
	output logic             pgm_pulse,
	output logic             ers_pulse,
	output logic      [11:0] op_mask,
	output logic      [11:0] pgm_addr,
	output logic      [7:0]  pgm_data,
	output logic      [1:0]  busy
);

	// Refuse timer loads that do not fit the counter
	if (PROG_CYC < 1 || PROG_CYC >= 2 ** `TMR_W || ERASE_CYC < 1 ||
		ERASE_CYC >= 2 ** `TMR_W) begin : g_bad_cyc
		$error("PROG_CYC or ERASE_CYC out of range");
	end

	localparam logic [`TMR_W-1:0] PROG_T  = PROG_CYC[`TMR_W-1:0];
	localparam logic [`TMR_W-1:0] ERASE_T = ERASE_CYC[`TMR_W-1:0];
	localparam logic [`TMR_W-1:0] WIN_T   = `TMR_W'(`WINDOW_CYC);

	// Sector bits owned by one array
	function automatic logic [11:0] bank_bits(input logic b);
		return b ? `BANK1_SECTORS : `BANK0_SECTORS;
	endfunction

	// Match one command cycle against address and data
	function automatic logic is_cmd(input logic [11:0] a, input logic [7:0] d,
		input logic [11:0] ea, input logic [7:0] ed);
		return (a == ea) && (d == ed);
	endfunction

	// Assemble the status word
	function automatic logic [7:0] status_word(input logic p7, input logic tg,
		input logic er, input logic ew);
		logic [7:0] s;
		s = 8'h00;
		s[`POLL_BIT] = ~p7;
		s[`TOGGLE_BIT] = tg;
		s[`ERROR_BIT] = er;
		s[`WINDOW_BIT] = ew;
		return s;
	endfunction

	seq_state_t        st [2];
	seq_state_t        next_st [2];
	logic [2:0]        step [2];
	logic [2:0]        next_step [2];
	logic [`TMR_W-1:0] tmr [2];
	logic [`TMR_W-1:0] next_tmr [2];
	logic [11:0]       mask [2];
	logic [11:0]       next_mask [2];
	logic [1:0]        tgl;
	logic [1:0]        next_tgl;
	logic [1:0]        err;
	logic [1:0]        next_err;
	logic [1:0]        pd7;
	logic [1:0]        next_pd7;
	logic [7:0]        next_rdata;
	logic              next_pgm_pulse;
	logic              next_ers_pulse;
	logic [11:0]       next_op_mask;
	logic [11:0]       next_pgm_addr;
	logic [7:0]        next_pgm_data;
	logic [1:0]        next_busy;
	logic [11:0]       sel;
	logic [1:0]        bank_hit;
	logic [2:0]        qsel;

	// Array selection from the sector selects
	assign sel = {secondary_sector_selects, primary_sector_selects};
	assign bank_hit = {|secondary_sector_selects, |primary_sector_selects}; // R21
	assign qsel = {addr[6], addr[1], addr[0]};

	// Per-array command sequencer and read multiplexer
	always_comb begin
		next_rdata = 8'h00;
		next_pgm_pulse = 1'b0;
		next_ers_pulse = 1'b0;
		next_op_mask = op_mask;
		next_pgm_addr = pgm_addr;
		next_pgm_data = pgm_data;
		next_tgl = tgl;
		next_err = err;
		next_pd7 = pd7;
		next_busy = 2'b00;
		for (int b = 0; b < 2; b++) begin
			next_st[b] = st[b];
			next_step[b] = step[b];
			next_mask[b] = mask[b];
			next_tmr[b] = (tmr[b] != '0) ? tmr[b] - 1'b1 : tmr[b];
			case (st[b])
				S_READ: begin
					if (rd && bank_hit[b]) begin
						next_rdata = array_rdata; // R23
					end
					if (wr && bank_hit[b]) begin
						next_step[b] = 3'h0;
						case (step[b])
							3'h0: if (is_cmd(addr, wdata, `ADDR_UNLOCK1, `CODE_UNLOCK1)) begin
								next_step[b] = 3'h1; // R19
							end
							3'h1: if (is_cmd(addr, wdata, `ADDR_UNLOCK2, `CODE_UNLOCK2)) begin
								next_step[b] = 3'h2; // R19
							end
							3'h2: if (addr == `ADDR_UNLOCK1) begin
								if (wdata == `CODE_QUERY) begin
									next_st[b] = S_QRY; // R1 R2
								end else if (wdata == `CODE_PROGRAM) begin
									next_step[b] = `STEP_PGM_DATA;
								end else if (wdata == `CODE_ERASE) begin
									next_step[b] = 3'h3;
								end
							end
							3'h3: if (is_cmd(addr, wdata, `ADDR_UNLOCK1, `CODE_UNLOCK1)) begin
								next_step[b] = 3'h4;
							end
							3'h4: if (is_cmd(addr, wdata, `ADDR_UNLOCK2, `CODE_UNLOCK2)) begin
								next_step[b] = 3'h5;
							end
							3'h5: if (is_cmd(addr, wdata, `ADDR_UNLOCK1, `CODE_BULK)) begin
								next_mask[b] = bank_bits(1'(b)); // R6
								next_st[b] = S_WIN;
								next_tmr[b] = '0;
							end else if (wdata == `CODE_SECTOR) begin
								next_mask[b] = sel & bank_bits(1'(b)); // R6
								next_st[b] = S_WIN;
								next_tmr[b] = WIN_T;
							end
							`STEP_PGM_DATA: if ((sel & bank_bits(1'(b)) & sector_protect) == '0) begin
								next_st[b] = S_PROG; // R6
								next_tmr[b] = PROG_T;
								next_pd7[b] = wdata[7];
								next_err[b] = |(wdata & ~array_rdata); // R15
								next_pgm_pulse = 1'b1;
								next_op_mask = sel & bank_bits(1'(b));
								next_pgm_addr = addr;
								next_pgm_data = wdata;
							end else begin
								next_step[b] = 3'h0; // R8
							end
							default: next_step[b] = 3'h0;
						endcase
					end
				end
				S_QRY: begin
					if (rd && bank_hit[b]) begin
						if (b == 0 && qsel == `QSEL_ID) begin
							next_rdata = ID_CODE; // R1
						end else if (qsel == `QSEL_PROT) begin
							next_rdata = {7'h00, |(sel & bank_bits(1'(b)) & sector_protect)}; // R3
						end else begin
							next_rdata = array_rdata;
						end
					end
					if (wr && bank_hit[b] && wdata == `CODE_RESET) begin
						next_st[b] = S_READ; // R20
						next_step[b] = 3'h0;
					end
				end
				S_WIN: begin
					if (rd && bank_hit[b]) begin
						next_rdata = status_word(1'b1, tgl[b], err[b], 1'b0); // R18
						next_tgl[b] = ~tgl[b]; // R10
					end
					if (wr && bank_hit[b] && wdata == `CODE_SECTOR) begin
						next_mask[b] = mask[b] | (sel & bank_bits(1'(b)));
						next_tmr[b] = WIN_T; // R18
					end else if (tmr[b] == '0) begin
						if ((mask[b] & ~sector_protect) == '0) begin
							next_st[b] = S_NOERASE; // R9
							next_tmr[b] = WIN_T;
						end else begin
							next_st[b] = S_ERASE;
							next_tmr[b] = ERASE_T;
							next_ers_pulse = 1'b1;
							next_op_mask = mask[b] & ~sector_protect;
						end
						next_pd7[b] = 1'b1; // R7
					end
				end
				S_PROG, S_ERASE: begin
					if (rd && bank_hit[b]) begin
						next_rdata = status_word(pd7[b], tgl[b], err[b],
							st[b] == S_ERASE); // R4 R5 R7 R22
						next_tgl[b] = ~tgl[b]; // R10
					end
					if (op_fail) begin
						next_err[b] = 1'b1; // R14
					end
					if (tmr[b] == '0) begin
						next_st[b] = (err[b] || op_fail) ? S_ERR : S_READ; // R11
						next_step[b] = 3'h0;
					end
				end
				S_NOERASE: begin
					if (rd && bank_hit[b]) begin
						next_rdata = status_word(1'b1, 1'b0, err[b], 1'b1); // R9 R13
					end
					if (tmr[b] == '0) begin
						next_st[b] = S_READ; // R9
						next_step[b] = 3'h0;
					end
				end
				S_ERR: begin
					if (rd && bank_hit[b]) begin
						next_rdata = status_word(pd7[b], tgl[b], err[b], st[b] == S_ERR);
						next_tgl[b] = ~tgl[b];
					end
					if (wr && bank_hit[b] && wdata == `CODE_RESET) begin
						next_err[b] = 1'b0; // R17
						next_st[b] = S_READ; // R20
						next_step[b] = 3'h0;
					end
				end
				default: begin
					next_st[b] = S_READ;
					next_step[b] = 3'h0;
				end
			endcase
			next_busy[b] = (next_st[b] == S_PROG) || (next_st[b] == S_ERASE) ||
				(next_st[b] == S_WIN) || (next_st[b] == S_NOERASE);
		end
	end

	// Register all sequencer state and outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int b = 0; b < 2; b++) begin
				st[b] <= S_READ;
				step[b] <= 3'h0;
				tmr[b] <= '0;
				mask[b] <= 12'h000;
			end
			tgl <= 2'h0;
			err <= 2'h0;
			pd7 <= 2'h0;
			rdata <= 8'h00;
			pgm_pulse <= 1'b0;
			ers_pulse <= 1'b0;
			op_mask <= 12'h000;
			pgm_addr <= 12'h000;
			pgm_data <= 8'h00;
			busy <= 2'h0;
		end else begin
			st <= next_st;
			step <= next_step;
			tmr <= next_tmr;
			mask <= next_mask;
			tgl <= next_tgl;
			err <= next_err;
			pd7 <= next_pd7;
			rdata <= next_rdata;
			pgm_pulse <= next_pgm_pulse;
			ers_pulse <= next_ers_pulse;
			op_mask <= next_op_mask;
			pgm_addr <= next_pgm_addr;
			pgm_data <= next_pgm_data;
			busy <= next_busy;
		end
	end

	// Checks on the primary array path
	logic prd;
	assign prd = rd && bank_hit[0] && !bank_hit[1];

	a_read_one_cycle: assert property (@(posedge clk) disable iff (!rst_n) // R22
		!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside the answer cycle");
	a_id_answer: assert property (@(posedge clk) disable iff (!rst_n) // R1
		st[0] == S_QRY && prd && qsel == `QSEL_ID |=> rdata == ID_CODE)
		else $error("identifier not returned");
	a_prot_answer: assert property (@(posedge clk) disable iff (!rst_n) // R3
		st[0] == S_QRY && prd && qsel == `QSEL_PROT
		|=> rdata == {7'h00, $past(|(primary_sector_selects & sector_protect[7:0]))})
		else $error("protection answer wrong");
	a_prog_poll: assert property (@(posedge clk) disable iff (!rst_n) // R5
		st[0] == S_PROG && prd |=> rdata[`POLL_BIT] == ~$past(pd7[0]))
		else $error("program polling bit not inverted");
	a_erase_poll: assert property (@(posedge clk) disable iff (!rst_n) // R7
		st[0] == S_ERASE && prd |=> !rdata[`POLL_BIT] && rdata[`WINDOW_BIT])
		else $error("erase polling bit not zero");
	a_prot_ignore: assert property (@(posedge clk) disable iff (!rst_n) // R8
		st[0] == S_READ && step[0] == `STEP_PGM_DATA && wr && bank_hit[0] &&
		|(sel & sector_protect & `BANK0_SECTORS) |=> st[0] == S_READ && !pgm_pulse)
		else $error("protected program not ignored");
	a_noerase_flags: assert property (@(posedge clk) disable iff (!rst_n) // R13
		st[0] == S_NOERASE && prd |=> rdata[7:6] == 2'b00)
		else $error("flags not held low for protected erase");
	a_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n) // R10
		(st[0] == S_PROG && prd) ##1 (st[0] == S_PROG && prd)
		|=> rdata[`TOGGLE_BIT] != $past(rdata[`TOGGLE_BIT]))
		else $error("toggle bit did not flip");
	a_err_clear: assert property (@(posedge clk) disable iff (!rst_n) // R17
		st[0] == S_ERR && wr && bank_hit[0] && wdata == `CODE_RESET
		|=> !err[0] && st[0] == S_READ)
		else $error("reset command did not clear error");
	a_win_close: assert property (@(posedge clk) disable iff (!rst_n) // R18
		st[0] == S_WIN && tmr[0] == '0 && !wr |=> st[0] inside {S_ERASE, S_NOERASE})
		else $error("erase window did not close");
	a_zero_one_err: assert property (@(posedge clk) disable iff (!rst_n) // R15
		st[0] == S_READ && step[0] == `STEP_PGM_DATA && wr && bank_hit[0] &&
		!bank_hit[1] && !(|(sel & sector_protect & `BANK0_SECTORS)) &&
		|(wdata & ~array_rdata) |=> err[0] && st[0] == S_PROG)
		else $error("zero to one program not flagged");

endmodule

// ===== testbench/flash_array_model.sv
// Byte array that sits behind the status path and stores program and erase results
`timescale 1ns/100ps
module flash_array_model (
	input  wire logic        clk,
	input  wire logic [11:0] addr,
	input  wire logic        pgm_pulse,
	input  wire logic        ers_pulse,
	input  wire logic [11:0] pgm_addr,
	input  wire logic [7:0]  pgm_data,
	output logic      [7:0]  array_rdata
);
	logic [7:0] mem [16];

	// Starts fully erased
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'hFF;
		end
	end

	// Stored byte for the addressed place, same cycle
	assign array_rdata = mem[addr[3:0]];

	// Programming can only clear bits; erase sets all to ones
	always @(posedge clk) begin
		if (ers_pulse) begin
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 8'hFF;
			end
		end else if (pgm_pulse) begin
			mem[pgm_addr[3:0]] <= mem[pgm_addr[3:0]] & pgm_data;
		end
	end
endmodule

// ===== testbench/flash_query_and_status_reporting_test.sv
// Self-checking bench for the flash status and query path
`timescale 1ns/100ps
module flash_query_and_status_reporting_test;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary identifier value
	logic        clk, rst_n, wr, rd, op_fail, pgm_pulse, ers_pulse;
	logic [11:0] addr, prot, op_mask, pgm_addr;
	logic [7:0]  wdata, ps, ard, rdata, pgm_data, d, e, pd;
	logic [3:0]  ss;
	logic [1:0]  busy;
	logic [11:0] pa;
	int          mismatches, samples_checked;

	flash_status_seq #(.PROG_CYC(16), .ERASE_CYC(64), .ID_CODE(ID)) DUT (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.primary_sector_selects(ps), .secondary_sector_selects(ss),
		.array_rdata(ard), .sector_protect(prot), .op_fail(op_fail), .rdata(rdata),
		.pgm_pulse(pgm_pulse), .ers_pulse(ers_pulse), .op_mask(op_mask),
		.pgm_addr(pgm_addr), .pgm_data(pgm_data), .busy(busy));

	flash_array_model MEM (.clk(clk), .addr(addr), .pgm_pulse(pgm_pulse),
		.ers_pulse(ers_pulse), .pgm_addr(pgm_addr), .pgm_data(pgm_data),
		.array_rdata(ard));

	// 25 MHz clock
	always #20 clk = ~clk;

	task check(input string n, input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One write strobe cycle
	task wr_b(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// One read strobe; answer taken in the following cycle
	task rd_b(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Two read strobes with no gap; each answer taken in its own cycle
	task rd2_b(input logic [11:0] a, output logic [7:0] v1, output logic [7:0] v2);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		#1 v1 = rdata;
		@(posedge clk);
		rd <= 1'b0;
		#1 v2 = rdata;
	endtask

	// Expected polling answer while a byte program runs
	function automatic logic [7:0] exp_poll(input logic [7:0] v);
		return {7'h00, ~v[7]};
	endfunction

	// Two unlock writes then the command byte
	task cmd(input logic [7:0] c);
		wr_b(12'h555, 8'hAA);
		wr_b(12'hAAA, 8'h55);
		wr_b(12'h555, c);
	endtask

	task erase_seq;
		cmd(8'h80);
		wr_b(12'h555, 8'hAA);
		wr_b(12'hAAA, 8'h55);
		wr_b(12'h000, 8'h30);
	endtask

	// Reads until two back-to-back reads agree, bounded
	task wait_done(input logic [11:0] a, output logic [7:0] v);
		logic [7:0] p;
		int         n;
		rd_b(a, p);
		for (n = 0; n < 3000; n++) begin
			rd_b(a, v);
			if (v === p) break;
			p = v;
		end
		check("completion", (n < 3000) ? 8'h01 : 8'h00, 8'h01);
	endtask

	task set_sel(input logic [7:0] p, input logic [3:0] s, input logic [11:0] pr);
		@(posedge clk);
		ps <= p;
		ss <= s;
		prot <= pr;
	endtask

	// Watchdog cuts a hang short
	initial begin
		#(40 * 60000);
		mismatches++;
		final_report();
	end

	initial begin
		clk = 0; rst_n = 0; wr = 0; rd = 0; op_fail = 0; addr = 0; wdata = 0;
		ps = 0; ss = 0; prot = 0;
		void'($urandom(91));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// Identifier and protection queries
		set_sel(8'h01, 4'h0, 12'h001);
		cmd(8'h90);
		rd_b(12'h001, d); check("ident", d, ID);
		rd_b(12'h002, d); check("prot_set", d, 8'h01);
		set_sel(8'h02, 4'h0, 12'h001);
		rd_b(12'h002, d); check("prot_clear", d, 8'h00);
		wr_b(12'h000, 8'hF0);
		rd_b(12'h003, d); check("array_back", d, 8'hFF);
		$display("query test done");
		// Program a random byte and follow its status
		set_sel(8'h01, 4'h0, 12'h000);
		pa = {8'h00, 2'b00, 2'($urandom % 4)};
		pd = 8'($urandom % 255);
		cmd(8'hA0);
		wr_b(pa, pd);
		rd_b(pa, d); check("poll_bit", {7'h00, d[7]}, exp_poll(pd));
		check("err_low", {7'h00, d[5]}, 8'h00);
		check("busy_prog", {6'h00, busy}, 8'h01);
		rd2_b(pa, d, e); check("toggle", {7'h00, e[6]}, {7'h00, ~d[6]});
		set_sel(8'h00, 4'h1, 12'h000);
		rd_b(pa, d); check("other_bank", d, pd);
		set_sel(8'h01, 4'h0, 12'h000);
		wait_done(pa, d); check("prog_result", d, pd);
		check("busy_idle", {6'h00, busy}, 8'h00);
		check("pgm_addr", pgm_addr, pa);
		check("pgm_data", pgm_data, pd);
		check("prog_mask", op_mask, 12'h001);
		$display("program test done");
		// Program into a protected sector is ignored
		set_sel(8'h01, 4'h0, 12'h001);
		cmd(8'hA0);
		wr_b(12'h00C, 8'h00);
		rd_b(12'h00C, d); check("prot_program", d, 8'hFF);
		// Clearing to zero, then a zero-to-one attempt
		set_sel(8'h01, 4'h0, 12'h000);
		cmd(8'hA0);
		wr_b(12'h00C, 8'h00);
		wait_done(12'h00C, d); check("zero_byte", d, 8'h00);
		cmd(8'hA0);
		wr_b(12'h00C, 8'hFF);
		repeat (40) @(posedge clk);
		rd_b(12'h00C, d); check("err_set", {7'h00, d[5]}, 8'h01);
		wr_b(12'h000, 8'hF0);
		rd_b(12'h00C, d); check("err_cleared", d, 8'h00);
		$display("error test done");
		// Erase of a protected sector only
		set_sel(8'h02, 4'h0, 12'h002);
		erase_seq();
		rd_b(12'h00C, d); check("win_flags", d & 8'h88, 8'h00);
		repeat (2510) @(posedge clk);
		rd_b(12'h00C, d); check("noerase", d & 8'hC8, 8'h08);
		repeat (2510) @(posedge clk);
		rd_b(12'h00C, d); check("noerase_end", d, 8'h00);
		$display("protected erase test done");
		// Real sector erase
		set_sel(8'h02, 4'h0, 12'h000);
		erase_seq();
		repeat (2505) @(posedge clk);
		rd_b(12'h00C, d); check("erase_flags", d & 8'h88, 8'h08);
		check("erase_mask", op_mask, 12'h002);
		// Internal failure during the erase raises the error flag
		@(posedge clk);
		op_fail <= 1'b1;
		@(posedge clk);
		op_fail <= 1'b0;
		repeat (80) @(posedge clk);
		rd_b(12'h00C, d); check("erase_fail", {7'h00, d[5]}, 8'h01);
		wr_b(12'h000, 8'hF0);
		wait_done(12'h00C, d); check("erased", d, 8'hFF);
		$display("erase test done");
		final_report();
	end
endmodule
